// >>> rtl/energy_meter_map.svh
// register offsets, field positions, reset values and timing counts of the energy meter
`ifndef ENERGY_METER_MAP_SVH
`define ENERGY_METER_MAP_SVH

// address layout
`define EM_PAGE_W 7
`define EM_INDEX_W 5
`define EM_ADDR_W 12
`define EM_DATA_W 24
`define EM_PAGE_COUNT 128
`define EM_PAGE_SIZE 32

// pages in use
`define EM_PAGE_RESULTS 7'h00
`define EM_PAGE_EVENTS 7'h02
`define EM_PAGE_TEMP 7'h05
`define EM_PAGE_RESET 7'h00

// page 0 locations
`define EM_OFF_CONFIGURATION 5'h00
`define EM_OFF_INST_CURRENT_CH1 5'h01
`define EM_OFF_INST_VOLTAGE_CH1 5'h02
`define EM_OFF_INST_POWER_CH1 5'h03
`define EM_OFF_ACTIVE_POWER_CH1 5'h04
`define EM_OFF_RMS_CURRENT_CH1 5'h05
`define EM_OFF_RMS_VOLTAGE_CH1 5'h06
`define EM_OFF_INST_CURRENT_CH2 5'h07
`define EM_OFF_INST_VOLTAGE_CH2 5'h08
`define EM_OFF_INST_POWER_CH2 5'h09
`define EM_OFF_ACTIVE_POWER_CH2 5'h0A
`define EM_OFF_RMS_CURRENT_CH2 5'h0B
`define EM_OFF_RMS_VOLTAGE_CH2 5'h0C
`define EM_OFF_INST_QUAD_CH1 5'h0E
`define EM_OFF_INST_QUAD_CH2 5'h11
`define EM_OFF_PAGE_SELECT 5'h1F

// page 2 and page 5 locations
`define EM_OFF_SAG_DURATION_CH1 5'h00
`define EM_OFF_SAG_LEVEL_CH1 5'h01
`define EM_OFF_FAULT_DURATION_CH1 5'h04
`define EM_OFF_FAULT_LEVEL_CH1 5'h05
`define EM_OFF_SAG_DURATION_CH2 5'h08
`define EM_OFF_SAG_LEVEL_CH2 5'h09
`define EM_OFF_FAULT_DURATION_CH2 5'h0C
`define EM_OFF_FAULT_LEVEL_CH2 5'h0D
`define EM_OFF_TEMPERATURE_MEASURE 5'h1A

// configuration fields
`define EM_CFG_RESET 24'h000001
`define EM_CFG_WRITE_MASK 24'hFF981F
`define EM_CFG_PHASE_MSB 23
`define EM_CFG_PHASE_LSB 16
`define EM_CFG_OPEN_DRAIN_BIT 15
`define EM_CFG_IRQ_PULSE_BIT 12
`define EM_CFG_IRQ_POL_BIT 11
`define EM_CFG_CLK_INV_BIT 4
`define EM_CFG_DIV_MSB 3
`define EM_CFG_DIV_LSB 0

// command byte fields
`define EM_CMD_TOP_BIT 7
`define EM_CMD_WRITE_BIT 6
`define EM_CMD_INDEX_MSB 5
`define EM_CMD_INDEX_LSB 1
`define EM_CMD_LOW_BIT 0
`define EM_CMD_BITS 5'h08
`define EM_DATA_BITS 5'h18

// processing constants
`define EM_INTERVAL_SHIFT 12
`define EM_INTERVAL_LAST 12'hFFF
`define EM_QUAD_DELAY 4
`define EM_PHASE_SHIFT 7
`define EM_IRQ_PULSE_CYCLES 5'h10

`endif

// >>> rtl/energy_meter_pkg.sv
// types shared by the energy meter register bank and its serial port
package energy_meter_pkg;

	// one decoded register write from the serial port
	typedef struct packed {
		logic [4:0] index;
		logic [23:0] data;
	} reg_write_t;

	// one sample pair of a channel, signed fractions
	typedef struct packed {
		logic signed [23:0] current;
		logic signed [23:0] voltage;
	} channel_sample_t;

	// a driven pin: level and output enable
	typedef struct packed {
		logic level;
		logic oe;
	} pin_drive_t;

	// serial command port states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CMD = 2'b01,
		ST_WDATA = 2'b10,
		ST_RDATA = 2'b11
	} serial_state_t;

endpackage

// >>> rtl/clock_divider.sv
// divides the master clock by K into a one-cycle internal clock enable
`timescale 1ns/100ps
`default_nettype none
`include "energy_meter_map.svh"

module clock_divider (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] div_field,
	output logic tick
);
	logic [4:0] count_reg; // cycles since last tick
	logic [4:0] divisor; // K, 1 to 16

	// a zero field means divide by sixteen
	always_comb begin
		divisor = (div_field == 4'h0) ? 5'h10 : {1'b0, div_field};
	end

	// count up to K-1; a smaller K written mid-count wraps at once
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= 5'h00;
		end else if (count_reg >= divisor - 5'h01) begin
			count_reg <= 5'h00;
		end else begin
			count_reg <= count_reg + 5'h01;
		end
	end

	// tick on the last cycle of each period
	assign tick = (count_reg >= divisor - 5'h01);
endmodule // clock_divider

`default_nettype wire

// >>> rtl/serial_cmd_port.sv
// three-wire serial command port: command byte, 24-bit write and read data
`timescale 1ns/100ps
`default_nettype none
`include "energy_meter_map.svh"

module serial_cmd_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	output logic wr_valid,
	output energy_meter_pkg::reg_write_t wr,
	output logic rd_strobe,
	output logic [4:0] rd_index,
	input wire logic [23:0] rd_data
);
	logic [2:0] meta1_reg; // first stage, read only by second
	logic [2:0] meta2_reg; // second stage
	logic [2:0] meta3_reg; // third stage
	logic [2:0] pins_reg; // filtered {sclk, cs_n, sdi}
	logic sclk_prev_reg; // filtered sclk one cycle ago
	logic rise; // sclk rising, frame open
	logic fall; // sclk falling, frame open
	logic frame; // chip select active
	energy_meter_pkg::serial_state_t state_reg;
	logic [4:0] count_reg; // bits taken in this field
	logic [23:0] in_reg; // incoming shift
	logic [23:0] out_reg; // outgoing shift
	logic [7:0] cmd; // command byte as it completes
	logic [23:0] word; // write word as it completes

	// three flip-flops per pin; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta1_reg <= 3'h2;
			meta2_reg <= 3'h2;
			meta3_reg <= 3'h2;
			pins_reg <= 3'h2;
		end else begin
			meta1_reg <= {sclk, cs_n, sdi};
			meta2_reg <= meta1_reg;
			meta3_reg <= meta2_reg;
			for (int b = 0; b < 3; b++) begin
				if (meta2_reg[b] == meta3_reg[b]) begin
					pins_reg[b] <= meta3_reg[b];
				end
			end
		end
	end

	// edge detect on the filtered clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= pins_reg[2];
		end
	end

	assign frame = ~pins_reg[1];
	assign rise = frame & pins_reg[2] & ~sclk_prev_reg;
	assign fall = frame & ~pins_reg[2] & sclk_prev_reg;
	assign cmd = {in_reg[6:0], pins_reg[0]};
	assign word = {in_reg[22:0], pins_reg[0]};

	// field sequencing; chip select high aborts any unfinished field
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= energy_meter_pkg::ST_IDLE;
			count_reg <= 5'h00;
			in_reg <= 24'h000000;
			wr_valid <= 1'b0;
			wr <= '0;
			rd_strobe <= 1'b0;
			rd_index <= 5'h00;
		end else begin
			wr_valid <= 1'b0;
			rd_strobe <= 1'b0;
			if (!frame) begin
				state_reg <= energy_meter_pkg::ST_IDLE;
				count_reg <= 5'h00;
			end else if (rise) begin
				in_reg <= word;
				count_reg <= count_reg + 5'h01;
				case (state_reg)
					energy_meter_pkg::ST_IDLE, energy_meter_pkg::ST_CMD: begin
						if (count_reg == `EM_CMD_BITS - 5'h01) begin
							count_reg <= 5'h00;
							state_reg <= energy_meter_pkg::ST_CMD;
							// bytes with a one in either end bit are other commands
							if (!cmd[`EM_CMD_TOP_BIT] && !cmd[`EM_CMD_LOW_BIT]) begin
								rd_index <= cmd[`EM_CMD_INDEX_MSB:`EM_CMD_INDEX_LSB];
								wr.index <= cmd[`EM_CMD_INDEX_MSB:`EM_CMD_INDEX_LSB];
								if (cmd[`EM_CMD_WRITE_BIT]) begin
									state_reg <= energy_meter_pkg::ST_WDATA;
								end else begin
									state_reg <= energy_meter_pkg::ST_RDATA;
									rd_strobe <= 1'b1;
								end
							end
						end
					end
					energy_meter_pkg::ST_WDATA: begin
						// load only once the last data bit is in
						if (count_reg == `EM_DATA_BITS - 5'h01) begin
							count_reg <= 5'h00;
							wr.data <= word;
							wr_valid <= 1'b1;
							state_reg <= energy_meter_pkg::ST_CMD;
						end
					end
					energy_meter_pkg::ST_RDATA: begin
						if (count_reg == `EM_DATA_BITS - 5'h01) begin
							count_reg <= 5'h00;
							state_reg <= energy_meter_pkg::ST_CMD;
						end
					end
					default: begin
						state_reg <= energy_meter_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// read data leaves msb first, advancing on each falling edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_reg <= 24'h000000;
		end else if (rd_strobe) begin
			out_reg <= rd_data;
		end else if (fall && state_reg == energy_meter_pkg::ST_RDATA) begin
			out_reg <= {out_reg[22:0], 1'b0};
		end
	end

	assign sdo = out_reg[23];
	assign sdo_oe = frame;
endmodule // serial_cmd_port

`default_nettype wire

// >>> rtl/energy_meter_regs.sv
// paged register bank and result arithmetic of the two-channel energy meter
`timescale 1ns/100ps
`default_nettype none
`include "energy_meter_map.svh"

module energy_meter_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire logic sample_valid,
	input wire energy_meter_pkg::channel_sample_t sample_ch1,
	input wire energy_meter_pkg::channel_sample_t sample_ch2,
	input wire logic energy_pulse_a,
	input wire logic energy_pulse_b,
	output energy_meter_pkg::pin_drive_t energy_pulse_out_a,
	output energy_meter_pkg::pin_drive_t energy_pulse_out_b,
	input wire logic irq_pending,
	input wire logic irq_new,
	output logic irq_out,
	output logic host_clock_out,
	output logic internal_clock
);
	// register file
	logic [6:0] page_reg; // selected page, write-only
	logic [23:0] config_reg; // configuration
	logic [23:0] event_reg [8]; // page 2 sag and fault settings
	logic [23:0] temp_reg; // page 5 temperature measurement
	logic [23:0] inst_i_reg [2]; // instantaneous current
	logic [23:0] inst_v_reg [2]; // instantaneous voltage
	logic [23:0] inst_p_reg [2]; // instantaneous power
	logic [23:0] inst_q_reg [2]; // instantaneous quadrature power
	logic [23:0] mean_power_reg [2]; // active power
	logic [23:0] rms_i_reg [2]; // rms current
	logic [23:0] rms_v_reg [2]; // rms voltage

	// accumulation state
	logic [11:0] sample_count_reg; // samples in this interval
	logic signed [36:0] p_sum_reg [2]; // power sum
	logic [59:0] i2_sum_reg [2]; // current squared sum
	logic [59:0] v2_sum_reg [2]; // voltage squared sum
	logic [23:0] v_hist_reg [2][`EM_QUAD_DELAY]; // past voltages, 0 newest

	// serial port and misc
	logic wr_valid;
	energy_meter_pkg::reg_write_t wr;
	logic rd_strobe;
	logic [4:0] rd_index;
	logic [23:0] rd_data;
	logic [11:0] wr_addr; // full internal write address
	logic [11:0] rd_addr; // full internal read address
	logic tick; // internal clock enable
	logic take; // sample accepted this cycle
	logic last; // sample closes the interval
	logic [23:0] v_comp; // phase-compensated channel 1 voltage
	logic [23:0] cur [2]; // incoming current per channel
	logic [23:0] volt [2]; // incoming voltage per channel
	logic clk_toggle_reg; // internal clock level
	logic [4:0] irq_count_reg; // pulse cycles remaining

	// signed Q1.23 product, saturating the single overflow case -1 * -1
	function automatic logic [23:0] frac_mul(input logic [23:0] a, input logic [23:0] b);
		logic signed [47:0] prod;
		prod = $signed(a) * $signed(b);
		if (prod == 48'sh400000000000) begin
			frac_mul = 24'h7FFFFF;
		end else begin
			frac_mul = prod[46:23];
		end
	endfunction

	// rms of an interval: square root of the mean square as a 0.24 fraction
	function automatic logic [23:0] rms_of(input logic [59:0] sum);
		logic [49:0] ms;
		logic [24:0] root;
		logic [24:0] trial;
		ms = {sum[59:`EM_INTERVAL_SHIFT], 2'b00};
		root = 25'h0000000;
		for (int b = 24; b >= 0; b--) begin
			trial = root | (25'h0000001 << b);
			// 50-bit square against 50-bit mean
			if ({25'h0, trial} * {25'h0, trial} <= ms) begin
				root = trial;
			end
		end
		// a full-scale square would reach one, which cannot be stored
		rms_of = root[24] ? 24'hFFFFFF : root[23:0];
	endfunction

	// square of a signed sample, Q2.46
	function automatic logic [47:0] square(input logic [23:0] a);
		logic signed [47:0] prod;
		prod = $signed(a) * $signed(a);
		square = prod;
	endfunction

	serial_cmd_port port (
		.clk(clk),
		.rst_n(rst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.sdi(sdi),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.wr_valid(wr_valid),
		.wr(wr),
		.rd_strobe(rd_strobe),
		.rd_index(rd_index),
		.rd_data(rd_data)
	);

	clock_divider divider (
		.clk(clk),
		.rst_n(rst_n),
		.div_field(config_reg[`EM_CFG_DIV_MSB:`EM_CFG_DIV_LSB]),
		.tick(tick)
	);

	// page supplies the high bits, the command the low five
	assign wr_addr = {page_reg, wr.index};
	assign rd_addr = {page_reg, rd_index};
	// samples only count on internal clock ticks
	assign take = sample_valid & tick;
	assign last = (sample_count_reg == `EM_INTERVAL_LAST);
	assign cur[0] = sample_ch1.current;
	assign cur[1] = sample_ch2.current;
	assign volt[0] = v_comp;
	assign volt[1] = sample_ch2.voltage;

	// page select answers at 31 on every page
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			page_reg <= `EM_PAGE_RESET;
		end else if (wr_valid && wr.index == `EM_OFF_PAGE_SELECT) begin
			page_reg <= wr.data[6:0];
		end
	end

	// configuration; unpublished bits are kept at zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			config_reg <= `EM_CFG_RESET;
		end else if (wr_valid && wr_addr == {`EM_PAGE_RESULTS, `EM_OFF_CONFIGURATION}) begin
			config_reg <= wr.data & `EM_CFG_WRITE_MASK;
		end
	end

	// sag, fault and temperature settings; other locations ignore writes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int n = 0; n < 8; n++) begin
				event_reg[n] <= 24'h000000;
			end
			temp_reg <= 24'h000000;
		end else if (wr_valid) begin
			if (wr_addr == {`EM_PAGE_TEMP, `EM_OFF_TEMPERATURE_MEASURE}) begin
				temp_reg <= wr.data;
			end else if (page_reg == `EM_PAGE_EVENTS && wr.index[4] == 1'b0
				&& wr.index[1] == 1'b0) begin
				// locations 0,1,4,5,8,9,12,13 pack into eight slots
				event_reg[{wr.index[3:2], wr.index[0]}] <= wr.data;
			end
		end
	end

	// read decode; unpopulated pages and locations read as zero
	always_comb begin
		rd_data = 24'h000000;
		if (rd_addr == {`EM_PAGE_TEMP, `EM_OFF_TEMPERATURE_MEASURE}) begin
			rd_data = temp_reg;
		end else if (page_reg == `EM_PAGE_EVENTS) begin
			if (rd_index[4] == 1'b0 && rd_index[1] == 1'b0) begin
				rd_data = event_reg[{rd_index[3:2], rd_index[0]}];
			end
		end else if (page_reg == `EM_PAGE_RESULTS) begin
			if (rd_index == `EM_OFF_CONFIGURATION) begin
				rd_data = config_reg;
			end else if (rd_index == `EM_OFF_INST_CURRENT_CH1) begin
				rd_data = inst_i_reg[0];
			end else if (rd_index == `EM_OFF_INST_VOLTAGE_CH1) begin
				rd_data = inst_v_reg[0];
			end else if (rd_index == `EM_OFF_INST_POWER_CH1) begin
				rd_data = inst_p_reg[0];
			end else if (rd_index == `EM_OFF_ACTIVE_POWER_CH1) begin
				rd_data = mean_power_reg[0];
			end else if (rd_index == `EM_OFF_RMS_CURRENT_CH1) begin
				rd_data = rms_i_reg[0];
			end else if (rd_index == `EM_OFF_RMS_VOLTAGE_CH1) begin
				rd_data = rms_v_reg[0];
			end else if (rd_index == `EM_OFF_INST_CURRENT_CH2) begin
				rd_data = inst_i_reg[1];
			end else if (rd_index == `EM_OFF_INST_VOLTAGE_CH2) begin
				rd_data = inst_v_reg[1];
			end else if (rd_index == `EM_OFF_INST_POWER_CH2) begin
				rd_data = inst_p_reg[1];
			end else if (rd_index == `EM_OFF_ACTIVE_POWER_CH2) begin
				rd_data = mean_power_reg[1];
			end else if (rd_index == `EM_OFF_RMS_CURRENT_CH2) begin
				rd_data = rms_i_reg[1];
			end else if (rd_index == `EM_OFF_RMS_VOLTAGE_CH2) begin
				rd_data = rms_v_reg[1];
			end else if (rd_index == `EM_OFF_INST_QUAD_CH1) begin
				rd_data = inst_q_reg[0];
			end else if (rd_index == `EM_OFF_INST_QUAD_CH2) begin
				rd_data = inst_q_reg[1];
			end
		end
	end

	// phase compensation: interpolate toward the previous voltage sample,
	// pc/128 of one sample; negative values extrapolate ahead
	always_comb begin
		logic signed [24:0] diff;
		logic signed [33:0] corr;
		logic signed [25:0] sum;
		diff = $signed({v_hist_reg[0][0][23], v_hist_reg[0][0]})
			- $signed({sample_ch1.voltage[23], sample_ch1.voltage});
		corr = (34'(diff) * 34'(
			$signed(config_reg[`EM_CFG_PHASE_MSB:`EM_CFG_PHASE_LSB]))) >>> `EM_PHASE_SHIFT;
		sum = $signed({{2{sample_ch1.voltage[23]}}, sample_ch1.voltage}) + corr[25:0];
		// saturate back to the fraction range
		if (sum > 26'sh07FFFFF) begin
			v_comp = 24'h7FFFFF;
		end else if (sum < -26'sh0800000) begin
			v_comp = 24'h800000;
		end else begin
			v_comp = sum[23:0];
		end
	end

	// instantaneous results and voltage history per sample
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int c = 0; c < 2; c++) begin
				inst_i_reg[c] <= 24'h000000;
				inst_v_reg[c] <= 24'h000000;
				inst_p_reg[c] <= 24'h000000;
				inst_q_reg[c] <= 24'h000000;
				for (int d = 0; d < `EM_QUAD_DELAY; d++) begin
					v_hist_reg[c][d] <= 24'h000000;
				end
			end
		end else if (take) begin
			for (int c = 0; c < 2; c++) begin
				inst_i_reg[c] <= cur[c];
				inst_v_reg[c] <= volt[c];
				inst_p_reg[c] <= frac_mul(cur[c], volt[c]);
				// the oldest tap stands for a quarter line period
				inst_q_reg[c] <= frac_mul(cur[c], v_hist_reg[c][`EM_QUAD_DELAY - 1]);
				v_hist_reg[c][0] <= (c == 0) ? sample_ch1.voltage : volt[c];
				for (int d = 1; d < `EM_QUAD_DELAY; d++) begin
					v_hist_reg[c][d] <= v_hist_reg[c][d - 1];
				end
			end
		end
	end

	// interval sums; the closing sample starts the next interval's squared sums, the sample before it starts the power sum
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_count_reg <= 12'h000;
			for (int c = 0; c < 2; c++) begin
				p_sum_reg[c] <= 37'sh0;
				i2_sum_reg[c] <= 60'h0;
				v2_sum_reg[c] <= 60'h0;
			end
		end else if (take) begin
			sample_count_reg <= sample_count_reg + 12'h001;
			for (int c = 0; c < 2; c++) begin
				if (last) begin
					p_sum_reg[c] <= 37'($signed(inst_p_reg[c]));
					i2_sum_reg[c] <= {12'h000, square(cur[c])};
					v2_sum_reg[c] <= {12'h000, square(volt[c])};
				end else begin
					p_sum_reg[c] <= p_sum_reg[c] + 37'($signed(inst_p_reg[c]));
					i2_sum_reg[c] <= i2_sum_reg[c] + {12'h000, square(cur[c])};
					v2_sum_reg[c] <= v2_sum_reg[c] + {12'h000, square(volt[c])};
				end
			end
		end
	end

	// interval results: mean power and rms, one update per interval
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int c = 0; c < 2; c++) begin
				mean_power_reg[c] <= 24'h000000;
				rms_i_reg[c] <= 24'h000000;
				rms_v_reg[c] <= 24'h000000;
			end
		end else if (take && last) begin
			for (int c = 0; c < 2; c++) begin
				mean_power_reg[c] <= p_sum_reg[c][35:12];
				rms_i_reg[c] <= rms_of(i2_sum_reg[c]);
				rms_v_reg[c] <= rms_of(v2_sum_reg[c]);
			end
		end
	end

	// internal clock and its copy on the host clock pin
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clk_toggle_reg <= 1'b0;
			host_clock_out <= 1'b0;
		end else begin
			if (tick) begin
				clk_toggle_reg <= ~clk_toggle_reg;
			end
			host_clock_out <= clk_toggle_reg ^ config_reg[`EM_CFG_CLK_INV_BIT];
		end
	end

	assign internal_clock = clk_toggle_reg;

	// energy pulse pins: pushed levels, or open drain that only pulls low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			energy_pulse_out_a <= '{level: 1'b1, oe: 1'b1};
			energy_pulse_out_b <= '{level: 1'b1, oe: 1'b1};
		end else if (config_reg[`EM_CFG_OPEN_DRAIN_BIT]) begin
			energy_pulse_out_a <= '{level: 1'b0, oe: ~energy_pulse_a};
			energy_pulse_out_b <= '{level: 1'b0, oe: ~energy_pulse_b};
		end else begin
			energy_pulse_out_a <= '{level: energy_pulse_a, oe: 1'b1};
			energy_pulse_out_b <= '{level: energy_pulse_b, oe: 1'b1};
		end
	end

	// interrupt pin: level follows pending, pulse mode fires on each new event
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_count_reg <= 5'h00;
			irq_out <= 1'b1;
		end else begin
			if (irq_new) begin
				irq_count_reg <= `EM_IRQ_PULSE_CYCLES; // a new event restarts the pulse
			end else if (irq_count_reg != 5'h00) begin
				irq_count_reg <= irq_count_reg - 5'h01;
			end
			if (config_reg[`EM_CFG_IRQ_PULSE_BIT]) begin
				irq_out <= (irq_count_reg != 5'h00) ~^ config_reg[`EM_CFG_IRQ_POL_BIT];
			end else begin
				irq_out <= irq_pending ~^ config_reg[`EM_CFG_IRQ_POL_BIT];
			end
		end
	end
endmodule // energy_meter_regs

`default_nettype wire

// >>> bench/energy_meter_regs_sva.sv
// pin-level assertions for the energy meter register bank
`timescale 1ns/100ps
`default_nettype none
module energy_meter_regs_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic energy_pulse_a,
	input wire logic energy_pulse_b,
	input wire energy_meter_pkg::pin_drive_t energy_pulse_out_a,
	input wire energy_meter_pkg::pin_drive_t energy_pulse_out_b,
	input wire logic irq_pending,
	input wire logic irq_new,
	input wire logic irq_out,
	input wire logic internal_clock
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [4:0] quiet_reg; // cycles with no interrupt cause and no frame
	// a pulse may still be running or a mode write landing, so wait it out
	always_ff @(posedge clk) begin
		if (!rst_n || irq_new || irq_pending != $past(irq_pending) || !cs_n) quiet_reg <= 5'h00;
		else if (quiet_reg != 5'h1F) quiet_reg <= quiet_reg + 5'h01;
	end
	sequence s_desel; cs_n [*7]; endsequence
	sequence s_sel; !cs_n [*7]; endsequence
	sequence s_high; sclk [*8] ##1 sclk [*3]; endsequence
	property p_reset; $rose(rst_n) |-> energy_pulse_out_a == 2'h3 && energy_pulse_out_b == 2'h3
		&& irq_out && !internal_clock && !sdo_oe; endproperty
	property p_pin_a; (energy_pulse_out_a.oe ? energy_pulse_out_a.level : 1'b1) ==
		$past(energy_pulse_a) && (energy_pulse_out_a.oe || !energy_pulse_out_a.level); endproperty
	property p_pin_b; (energy_pulse_out_b.oe ? energy_pulse_out_b.level : 1'b1) ==
		$past(energy_pulse_b) && (energy_pulse_out_b.oe || !energy_pulse_out_b.level); endproperty
	property p_off; s_desel |-> !sdo_oe; endproperty
	property p_on; s_sel |-> sdo_oe; endproperty
	property p_tick; 1'b1 |-> ##[1:32] $changed(internal_clock); endproperty
	property p_sdo; s_high |-> $stable(sdo); endproperty
	property p_irq; quiet_reg > 5'h18 |-> $stable(irq_out); endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	a_pin_a: assert property (p_pin_a) else $error("pulse pin a drive wrong");
	a_pin_b: assert property (p_pin_b) else $error("pulse pin b drive wrong");
	a_off: assert property (p_off) else $error("sdo driven while deselected");
	a_on: assert property (p_on) else $error("sdo released while selected");
	a_tick: assert property (p_tick) else $error("internal clock stalled");
	a_sdo: assert property (p_sdo) else $error("sdo moved while sclk high");
	a_irq: assert property (p_irq) else $error("interrupt pin moved without cause");
endmodule // energy_meter_regs_sva
bind energy_meter_regs energy_meter_regs_sva u_energy_meter_regs_sva (.clk, .rst_n, .sclk,
	.cs_n, .sdo, .sdo_oe, .energy_pulse_a, .energy_pulse_b, .energy_pulse_out_a,
	.energy_pulse_out_b, .irq_pending, .irq_new, .irq_out, .internal_clock);
`default_nettype wire

// >>> bench/host_model.sv
// host side of the three-wire serial command port
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic sdo,
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	output logic rd_done,
	output logic [23:0] rd_word
);
	// idle: deselected, clock parked low
	initial begin
		{sclk, cs_n, sdi, rd_done} = 4'h4;
		rd_word = 24'h000000;
	end
	// wait n edges, then step just off the edge
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one frame: command byte then 24 bits, cut short after n pulses
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int n);
		logic [31:0] tx;
		tx = {cmd, wd};
		cs_n = 1'b0;
		hold(6);
		for (int p = 0; p < n; p++) begin
			sdi = tx[31 - p]; // msb first, changed while sclk low
			hold(12);
			sclk = 1'b1;
			hold(12);
			if (p >= 7 && p < 31) rd_word = {rd_word[22:0], sdo};
			sclk = 1'b0;
		end
		hold(6);
		cs_n = 1'b1;
		sdi = ~sdi; // no stale level between frames
		rd_done = !cmd[6] && n == 32;
		hold(1);
		rd_done = 1'b0;
		hold(8);
	endtask
endmodule // host_model
`default_nettype wire

// >>> bench/energy_meter_regs_test.sv
// self-checking bench for the energy meter register bank
`timescale 1ns/100ps
`default_nettype none
module energy_meter_regs_test;
	logic clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, smp_v, pa, pb, ipend, inew;
	logic irq_out, hco, ick, rd_done;
	energy_meter_pkg::channel_sample_t s1, s2;
	energy_meter_pkg::pin_drive_t oa, ob;
	logic [23:0] rd_word, v;
	logic [23:0] exp_q[$]; // expected read words, oldest first
	int fail_count = 0;
	int total_checks = 0;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	energy_meter_regs u_energy_meter_regs (.clk, .rst_n, .sclk, .cs_n, .sdi, .sdo, .sdo_oe,
		.sample_valid(smp_v), .sample_ch1(s1), .sample_ch2(s2), .energy_pulse_a(pa),
		.energy_pulse_b(pb), .energy_pulse_out_a(oa), .energy_pulse_out_b(ob),
		.irq_pending(ipend), .irq_new(inew), .irq_out, .host_clock_out(hco),
		.internal_clock(ick));
	host_model u_host_model (.clk, .sdo, .sclk, .cs_n, .sdi, .rd_done, .rd_word);
	task automatic check(input logic [23:0] got, input logic [23:0] want);
		total_checks++;
		if (got !== want) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// each finished read is matched against the oldest note
	always @(posedge clk) if (rd_done) check(rd_word, exp_q.pop_front());
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		u_host_model.xfer({2'h1, a, 1'h0}, d, 32);
	endtask
	task automatic rd(input logic [4:0] a, input logic [23:0] e);
		smp_v = 1'b0;
		exp_q.push_back(e);
		u_host_model.xfer({2'h0, a, 1'h0}, 24'($urandom), 32);
	endtask
	// same pair on both channels; sampling runs on until the next read
	task automatic smp(input logic [23:0] i, input logic [23:0] vv, input int n);
		{s1, s2} = {i, vv, i, vv};
		smp_v = 1'b1;
		u_host_model.hold(n);
	endtask
	initial begin
		logic [4:0] loc [8];
		logic [23:0] dat [8];
		logic [3:0] k;
		int n;
		loc = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0C, 5'h0D};
		void'($urandom(22971));
		{rst_n, smp_v, ipend, inew, pa, pb} = 6'h03; // pulse inputs idle high
		{s1, s2} = 96'h0;
		u_host_model.hold(3); // three reset edges
		rst_n = 1'b1;
		u_host_model.hold(4);
		rd(5'h00, 24'h000001);
		wr(5'h1F, 24'h000002);
		foreach (loc[j]) begin
			dat[j] = 24'($urandom);
			wr(loc[j], dat[j]);
		end
		foreach (loc[j]) rd(loc[j], dat[j]);
		rd(5'h1F, 24'h000000);
		rd(5'h02, 24'h000000);
		u_host_model.xfer({2'h1, 5'h01, 1'h0}, ~dat[1], 20);
		rd(5'h01, dat[1]);
		wr(5'h1F, 24'h000005);
		v = 24'($urandom);
		wr(5'h1A, v);
		rd(5'h1A, v);
		rd(5'h00, 24'h000000);
		wr(5'h1F, 24'h00007F);
		rd(5'h00, 24'h000000);
		wr(5'h1F, 24'h000000);
		v = 24'($urandom) & 24'hFF981F;
		wr(5'h00, v);
		rd(5'h00, v);
		// drive mode against pin level
		for (int m = 0; m < 4; m++) begin
			wr(5'h00, {8'h00, m[1], 15'h0001});
			{pa, pb} = 2'($urandom);
			u_host_model.hold(3);
			check({oa, ob}, m[1] ? {1'b0, !pa, 1'b0, !pb} : {pa, 1'b1, pb, 1'b1});
		end
		// interrupt pin: idle, asserted, after the pulse, released
		for (int m = 0; m < 4; m++) begin
			wr(5'h00, {11'h000, m[1:0], 11'h001});
			u_host_model.hold(30);
			check(irq_out, !m[0]);
			{ipend, inew} = 2'h3;
			u_host_model.hold(1);
			inew = 1'b0;
			u_host_model.hold(3);
			check(irq_out, m[0]);
			u_host_model.hold(20);
			check(irq_out, m[0] ^ m[1]);
			ipend = 1'b0;
			u_host_model.hold(3);
			check(irq_out, !m[0]);
		end
		// divider spacing, clock inversion on the middle case
		for (int m = 0; m < 3; m++) begin
			k = m == 0 ? 4'h1 : (m == 1 ? 4'h3 : 4'h0);
			wr(5'h00, {19'h00000, m[0], k});
			u_host_model.hold(40);
			v[0] = ick;
			while (ick === v[0]) u_host_model.hold(1);
			v[0] = ick;
			n = 0;
			while (ick === v[0] && n < 40) begin
				u_host_model.hold(1);
				n++;
			end
			check(24'(n), k == 4'h0 ? 24'h000010 : {20'h00000, k});
			u_host_model.hold(1);
			if (m != 0) check(hco, ick ^ m[0]);
		end
		wr(5'h00, 24'h000001);
		v = 24'($urandom) & 24'hFFFFFC;
		smp(v, 24'hE00000, 1);
		smp(v, 24'h000000, 3);
		smp(v, 24'h200000, 1);
		rd(5'h01, v);
		rd(5'h02, 24'h200000);
		v = 24'($signed(v) >>> 2);
		rd(5'h03, v);
		rd(5'h0E, -v);
		rd(5'h11, -v);
		smp(24'hC00000, 24'h200000, 8192);
		rd(5'h04, 24'hF00000);
		rd(5'h05, 24'h800000);
		rd(5'h0C, 24'h400000);
		wr(5'h00, 24'h400001); // half a sample of delay
		smp(24'h400000, 24'h200000, 1);
		smp(24'h400000, 24'h000000, 1);
		rd(5'h02, 24'h100000);
		rd(5'h08, 24'h000000);
		tally_and_finish();
	end
	// hang guard, a little past the expected run length
	initial begin
		#600000;
		fail_count++;
		tally_and_finish();
	end
endmodule // energy_meter_regs_test
`default_nettype wire
